// ---- logic/srw_bus_watch.sv ----
// serial bus activity watcher that pulses on a watchdog restart sequence
`timescale 1ns/10ps
module srw_bus_watch (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // synchronised bus lines
    input wire logic scl,
    input wire logic sda,
    // restart pulse
    output logic restart
);
    srw_pkg::srw_watch_e state;
    logic scl_d;
    logic sda_d;
    logic start_seen;
    logic stop_seen;

    // start and stop are data edges while the clock stays high
    assign start_seen = scl && scl_d && sda_d && !sda;
    assign stop_seen = scl && scl_d && !sda_d && sda;

    // previous line levels for edge finding
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // sequence tracker; a repeated start simply starts over
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= srw_pkg::SRW_IDLE;
        end else if (ce) begin
            if (start_seen) begin
                state <= srw_pkg::SRW_STARTED;
            end else if (stop_seen) begin
                state <= srw_pkg::SRW_IDLE;
            end else begin
                case (state)
                    srw_pkg::SRW_STARTED: begin
                        if (!scl) state <= srw_pkg::SRW_CLK_LOW;
                    end
                    srw_pkg::SRW_CLK_LOW: begin
                        if (scl) state <= srw_pkg::SRW_CLK_HIGH;
                    end
                    default: state <= state;
                endcase
            end
        end
    end

    // a stop after at least one full clock completes a restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restart <= 1'b0;
        end else if (ce) begin
            restart <= stop_seen && state == srw_pkg::SRW_CLK_HIGH;
        end
    end

    sequence s_clocked_stop;
        ce && state == srw_pkg::SRW_CLK_HIGH && stop_seen;
    endsequence

    chk_restart_after_stop: assert property (@(posedge hclk)
        disable iff (!hresetn) s_clocked_stop |=> restart)
        else $error("clocked stop did not restart the watchdog");
endmodule : srw_bus_watch

// ---- logic/srw_pkg.sv ----
// constants and types shared by the supervisor, reset and watchdog logic
package srw_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 8;
    localparam int CNT_W = 21;
    localparam int TICKS_PER_MS = 1000;
    // hold and watchdog times in ms
    localparam int HOLD0_MS = 50;
    localparam int HOLD1_MS = 200;
    localparam int HOLD2_MS = 400;
    localparam int HOLD3_MS = 800;
    localparam int WD0_MS = 1400;
    localparam int WD1_MS = 200;
    localparam int WD2_MS = 25;
    // selector encodings and reset values
    localparam logic [1:0] WD_OFF = 2'h3;
    localparam logic [1:0] HOLD_SEL_RST = 2'h1;
    localparam logic [1:0] WD_SEL_RST = 2'h3;
    // register byte offsets
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
    // control field positions
    localparam int CTRL_HOLD_LSB = 0;
    localparam int CTRL_WD_LSB = 2;
    // event bits
    localparam int EV_CORE_LOW = 0;
    localparam int EV_SECOND_FAIL = 1;
    localparam int EV_THIRD_FAIL = 2;
    localparam int EV_WDOG = 3;
    localparam int EV_W = 4;
    // restart watcher states
    typedef enum logic [1:0] {
        SRW_IDLE = 2'b00,
        SRW_STARTED = 2'b01,
        SRW_CLK_LOW = 2'b10,
        SRW_CLK_HIGH = 2'b11
    } srw_watch_e;
endpackage : srw_pkg

// ---- logic/srw_supervisor.sv ----
// supply supervisor: reset hold, fail flags, watchdog and register slave
`timescale 1ns/10ps
module srw_supervisor #(
    parameter logic [20:0] HOLD0_TICKS = 21'(srw_pkg::HOLD0_MS * 1000),
    parameter logic [20:0] HOLD1_TICKS = 21'(srw_pkg::HOLD1_MS * 1000),
    parameter logic [20:0] HOLD2_TICKS = 21'(srw_pkg::HOLD2_MS * 1000),
    parameter logic [20:0] HOLD3_TICKS = 21'(srw_pkg::HOLD3_MS * 1000),
    parameter logic [20:0] WD0_TICKS = 21'(srw_pkg::WD0_MS * 1000),
    parameter logic [20:0] WD1_TICKS = 21'(srw_pkg::WD1_MS * 1000),
    parameter logic [20:0] WD2_TICKS = 21'(srw_pkg::WD2_MS * 1000),
    parameter logic [7:0] TICK_CYCLES = 8'(srw_pkg::TICK_CYCLES)
) (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // comparator results, high while the supply is above its threshold, then the active-low manual reset
    input wire logic core_supply_ok,
    input wire logic second_supply_sense,
    input wire logic third_supply_sense,
    input wire logic manual_reset_n,
    // two-wire bus pins, observed only
    input wire logic scl_in,
    input wire logic sda_in,
    // supervisor outputs
    output logic system_reset_n,
    output logic early_low_supply_n,
    output logic second_supply_fail_n,
    output logic third_supply_fail_n,
    output logic watchdog_expired_n,
    output logic irq
);
    localparam int CW = srw_pkg::CNT_W;
    localparam int EW = srw_pkg::EV_W;

    logic [5:0] sync1;
    logic [5:0] sync2;
    logic core_ok_s;
    logic second_ok_s;
    logic third_ok_s;
    logic mr_n_s;
    logic scl_s;
    logic sda_s;
    logic [srw_pkg::TICK_W-1:0] tick_cnt;
    logic tick;
    logic [1:0] hold_sel;
    logic [1:0] wd_sel;
    logic [CW-1:0] hold_cnt;
    logic [CW-1:0] wd_cnt;
    logic hold_fault;
    logic hold_done;
    logic wd_on;
    logic wd_end;
    logic restart;
    logic [EW-1:0] irq_stat;
    logic [EW-1:0] irq_mask;
    logic [EW-1:0] events;
    logic [EW-1:0] next_irq_stat;
    logic [EW-1:0] w1c;
    logic wr_pend;
    logic [3:0] wr_ofs;
    logic addr_ok;
    logic take;

    // terminal count of a two-bit selector; one helper for both timers
    function automatic logic [CW-1:0] pick(input logic [1:0] sel,
        input logic [CW-1:0] t0, input logic [CW-1:0] t1,
        input logic [CW-1:0] t2, input logic [CW-1:0] t3);
        case (sel)
            2'h0: pick = t0;
            2'h1: pick = t1;
            2'h2: pick = t2;
            default: pick = t3;
        endcase
    endfunction : pick

    // pins come from outside this clock, so two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else if (ce) begin
            sync1 <= {sda_in, scl_in, manual_reset_n, third_supply_sense,
                second_supply_sense, core_supply_ok};
            sync2 <= sync1;
        end
    end
    assign {sda_s, scl_s, mr_n_s, third_ok_s, second_ok_s, core_ok_s} = sync2;

    // single time base shared by the hold and watchdog counters
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= tick_cnt == TICK_CYCLES - 8'h01;
            if (tick_cnt == TICK_CYCLES - 8'h01) tick_cnt <= '0;
            else tick_cnt <= tick_cnt + 8'h01;
        end
    end

    // reset hold; below 1 V the comparator stays low, keeping reset held
    assign hold_fault = !core_ok_s || !mr_n_s;
    assign hold_done = tick && hold_cnt == pick(hold_sel, HOLD0_TICKS,
        HOLD1_TICKS, HOLD2_TICKS, HOLD3_TICKS) - 21'h000001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_reset_n <= 1'b0;
            hold_cnt <= '0;
        end else if (ce) begin
            if (hold_fault) begin
                system_reset_n <= 1'b0;
                hold_cnt <= '0;
            end else if (!system_reset_n) begin
                if (hold_done) begin
                    system_reset_n <= 1'b1;
                    hold_cnt <= '0;
                end else if (tick) begin
                    hold_cnt <= hold_cnt + 21'h000001;
                end
            end
        end
    end

    // direct flags, no hold applied to any of them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            early_low_supply_n <= 1'b0;
            second_supply_fail_n <= 1'b0;
            third_supply_fail_n <= 1'b0;
        end else if (ce) begin
            early_low_supply_n <= core_ok_s;
            second_supply_fail_n <= second_ok_s;
            third_supply_fail_n <= third_ok_s;
        end
    end

    srw_bus_watch u_watch (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .scl(scl_s),
        .sda(sda_s),
        .restart(restart)
    );

    // watchdog; stays expired until the next restart sequence or until it is switched off
    assign wd_on = wd_sel != srw_pkg::WD_OFF;
    assign wd_end = tick && wd_cnt == pick(wd_sel, WD0_TICKS, WD1_TICKS,
        WD2_TICKS, WD0_TICKS) - 21'h000001;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_cnt <= '0;
            watchdog_expired_n <= 1'b1;
        end else if (ce) begin
            if (!wd_on || restart) begin
                wd_cnt <= '0;
                watchdog_expired_n <= 1'b1;
            end else if (wd_end) begin
                watchdog_expired_n <= 1'b0;
            end else if (tick && watchdog_expired_n) begin
                wd_cnt <= wd_cnt + 21'h000001;
            end
        end
    end

    // ahb address phase; slave never inserts waits
    assign take = hsel && htrans[1] && hready;
    assign addr_ok = haddr[31:4] == 28'h0000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_ofs <= 4'h0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_pend <= take && hwrite && addr_ok;
            wr_ofs <= haddr[3:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take && !hwrite && addr_ok) begin
                case (haddr[3:0])
                    srw_pkg::CTRL_OFS: hrdata <= {28'h0000000, wd_sel,
                        hold_sel};
                    srw_pkg::STAT_OFS: hrdata <= {26'h0000000,
                        !watchdog_expired_n, !system_reset_n, mr_n_s,
                        third_ok_s, second_ok_s, core_ok_s};
                    srw_pkg::IRQ_STAT_OFS: hrdata <= {28'h0000000, irq_stat};
                    srw_pkg::IRQ_MASK_OFS: hrdata <= {28'h0000000, irq_mask};
                    default: hrdata <= 32'h00000000;
                endcase
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // stored period and hold selections, host writable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_sel <= srw_pkg::HOLD_SEL_RST;
            wd_sel <= srw_pkg::WD_SEL_RST;
            irq_mask <= '0;
        end else if (ce && wr_pend) begin
            if (wr_ofs == srw_pkg::CTRL_OFS) begin
                hold_sel <= hwdata[srw_pkg::CTRL_HOLD_LSB +: 2];
                wd_sel <= hwdata[srw_pkg::CTRL_WD_LSB +: 2];
            end
            if (wr_ofs == srw_pkg::IRQ_MASK_OFS) irq_mask <= hwdata[EW-1:0];
        end
    end

    // sticky events; a new event wins over a write-one clear
    // watchdog event only when the expiry really lands, not on a restart
    assign events = {wd_on && !restart && wd_end && watchdog_expired_n,
        third_supply_fail_n && !third_ok_s,
        second_supply_fail_n && !second_ok_s,
        early_low_supply_n && !core_ok_s};
    assign w1c = (wr_pend && wr_ofs == srw_pkg::IRQ_STAT_OFS) ?
        hwdata[EW-1:0] : '0;
    assign next_irq_stat = (irq_stat & ~w1c) | events;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fault;
        ce && hold_fault;
    endsequence

    chk_third_fail_follow: assert property (
        ce |=> third_supply_fail_n == $past(third_ok_s))
        else $error("third fail flag does not follow its comparator");
    chk_wdog_expiry: assert property (
        ce && wd_on && !restart && wd_end |=> !watchdog_expired_n)
        else $error("watchdog did not expire at its terminal count");
    chk_reset_at_start: assert property (
        !$past(hresetn) |-> !system_reset_n)
        else $error("reset not active after power-up");
    chk_release_after_hold: assert property (
        $rose(system_reset_n) |-> $past(hold_done) && $past(core_ok_s))
        else $error("reset released before hold time ended");
    chk_manual_hold: assert property (
        ce && !mr_n_s |=> !system_reset_n ##0 hold_cnt == 21'h000000)
        else $error("manual reset did not hold reset");
    chk_core_drop_reset: assert property (
        ce && !core_ok_s |=> !system_reset_n)
        else $error("core supply drop did not assert reset");
    chk_second_fail_follow: assert property (
        ce && !second_ok_s |=> !second_supply_fail_n)
        else $error("second fail flag not asserted");
    chk_second_recover: assert property (
        ce && second_ok_s |=> second_supply_fail_n)
        else $error("second fail flag not released");
    chk_early_low_follow: assert property (
        ce |=> early_low_supply_n == $past(core_ok_s))
        else $error("early low flag does not follow core comparator");
    chk_restart_clears: assert property (
        ce && restart |=> watchdog_expired_n && wd_cnt == 21'h000000)
        else $error("restart did not clear the watchdog");
    chk_wdog_disabled: assert property (
        ce && wd_sel == srw_pkg::WD_OFF |=> watchdog_expired_n)
        else $error("disabled watchdog expired");
    chk_fault_restarts_hold: assert property (
        s_fault ##1 (ce && !hold_fault)[*2] |=> !system_reset_n)
        else $error("hold not restarted after a new fault");
endmodule : srw_supervisor

// ---- test/srw_host_model.sv ----
// two-wire bus host model that produces watchdog restart sequences
`timescale 1ns/10ps
module srw_host_model (
    // clock and request handshake
    input wire logic hclk,
    input wire logic req,
    input wire logic [1:0] kind,
    output logic ack,
    // bus levels, released lines read high through the pull-ups
    output logic scl,
    output logic sda
);
    localparam int HALF_NS = 80;
    // address byte then a released acknowledge slot, nobody answers
    localparam logic [8:0] FRAME = 9'h141;
    logic [1:0] k;

    // kind 0 minimal, 1 full address frame, 2 start then stop only
    // the bus clock stands high between frames, as an idle bus does
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        ack = 1'b0;
        forever begin
            @(posedge hclk iff req);
            k = kind;
            #13;
            sda = 1'b0;
            #HALF_NS;
            if (k == 2'h1) begin
                for (int i = 8; i >= 0; i--) begin
                    scl = 1'b0;
                    #(HALF_NS / 2);
                    sda = FRAME[i];
                    #(HALF_NS / 2);
                    scl = 1'b1;
                    #HALF_NS;
                end
            end
            if (k != 2'h2) begin
                scl = 1'b0;
                #(HALF_NS / 2);
                sda = 1'b0;
                #(HALF_NS / 2);
                scl = 1'b1;
                #HALF_NS;
            end
            sda = 1'b1;
            @(posedge hclk);
            ack <= 1'b1;
            @(posedge hclk);
            ack <= 1'b0;
        end
    end
endmodule : srw_host_model

// ---- test/srw_supervisor_tb.sv ----
// self-checking bench for the supply supervisor and its watchdog
`timescale 1ns/10ps
module srw_supervisor_tb;
    // short counts keep the run brief; expectations derive from these
    localparam int TC = 4;
    localparam int HOLD_T[4] = '{5, 10, 15, 20};
    localparam int WD_T[3] = '{40, 20, 10};
    localparam logic [31:0] A_CTRL = {28'h0, srw_pkg::CTRL_OFS};
    localparam logic [31:0] A_STAT = {28'h0, srw_pkg::STAT_OFS};
    localparam logic [31:0] A_IRQS = {28'h0, srw_pkg::IRQ_STAT_OFS};
    localparam logic [31:0] A_MASK = {28'h0, srw_pkg::IRQ_MASK_OFS};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [1:0] htrans, kind;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic core_supply_ok, second_supply_sense, third_supply_sense;
    logic manual_reset_n, scl_in, sda_in, req, ack, system_reset_n;
    logic early_low_supply_n, second_supply_fail_n, third_supply_fail_n;
    logic watchdog_expired_n, ce;
    int error_cnt, checked, n;

    assign hready = hreadyout;

    srw_supervisor #(
        .HOLD0_TICKS(21'(HOLD_T[0])), .HOLD1_TICKS(21'(HOLD_T[1])),
        .HOLD2_TICKS(21'(HOLD_T[2])), .HOLD3_TICKS(21'(HOLD_T[3])),
        .WD0_TICKS(21'(WD_T[0])), .WD1_TICKS(21'(WD_T[1])),
        .WD2_TICKS(21'(WD_T[2])), .TICK_CYCLES(8'(TC))
    ) i_dut (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .core_supply_ok, .second_supply_sense, .third_supply_sense,
        .manual_reset_n, .scl_in, .sda_in, .system_reset_n,
        .early_low_supply_n, .second_supply_fail_n, .third_supply_fail_n,
        .watchdog_expired_n, .irq
    );

    srw_host_model i_host (
        .hclk, .req, .kind, .ack, .scl(scl_in), .sda(sda_in)
    );

    // 200 MHz system clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkb

    task automatic tick(input int k);
        repeat (k) @(posedge hclk);
    endtask : tick

    // bounded wait for a level, counting edges; a timeout ends the run
    task automatic wait_lvl(ref logic s, input logic v, input int lim,
                            output int c);
        c = 0;
        while (s !== v && c < lim) begin
            @(posedge hclk);
            c++;
        end
        if (s !== v) begin
            chkb(s, v);
            end_sim();
        end
    endtask : wait_lvl

    // release time must land within one tick before and three after
    task automatic win(input int c, input int t);
        chkb(c >= t * TC - TC && c <= t * TC + 3 * TC, 1'b1);
    endtask : win

    // one single ahb-lite transfer, address phase then data phase
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd);
        int c;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        wait_lvl(hreadyout, 1'b1, 50, c);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        wait_lvl(hreadyout, 1'b1, 50, c);
        rd = hrdata;
        chkb(hresp, 1'b0);
    endtask : bus

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // request one frame from the host model and hold until acknowledged
    task automatic host(input logic [1:0] k);
        int c;
        kind <= k;
        req <= 1'b1;
        @(posedge hclk);
        wait_lvl(ack, 1'b1, 1000, c);
        req <= 1'b0;
    endtask : host

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, req, kind} = '0;
        hsize = 3'h2;
        {core_supply_ok, second_supply_sense, third_supply_sense} = 3'h7;
        manual_reset_n = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        checked = 0;
        tick(2);
        chkb(system_reset_n, 1'b0);
        chkb(watchdog_expired_n, 1'b1);
        hresetn <= 1'b1;
        wait_lvl(system_reset_n, 1'b1, 400, n);
        win(n, HOLD_T[1]);
        rdchk(A_CTRL, 32'h0000_000D);
        rdchk(A_STAT, 32'h0000_000F);
        bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
        rdchk(32'h0000_0010, 32'h0);
        rdchk(A_CTRL, 32'h0000_000D);
        bus(1'b1, A_IRQS, 32'h0000_000F);
        // brownout, then a second dip in mid-hold restarts the count
        core_supply_ok <= 1'b0;
        wait_lvl(early_low_supply_n, 1'b0, 5, n);
        wait_lvl(system_reset_n, 1'b0, 5, n);
        tick(30 * TC);
        chkb(system_reset_n, 1'b0);
        rdchk(A_IRQS, 32'h0000_0001);
        core_supply_ok <= 1'b1;
        wait_lvl(early_low_supply_n, 1'b1, 5, n);
        chkb(system_reset_n, 1'b0);
        tick(HOLD_T[1] * TC / 2);
        core_supply_ok <= 1'b0;
        tick(3);
        core_supply_ok <= 1'b1;
        wait_lvl(system_reset_n, 1'b1, 400, n);
        win(n, HOLD_T[1]);
        // manual reset with every hold selection
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, A_CTRL, 32'(12 + s));
            manual_reset_n <= 1'b0;
            wait_lvl(system_reset_n, 1'b0, 5, n);
            tick(HOLD_T[3] * TC);
            chkb(system_reset_n, 1'b0);
            manual_reset_n <= 1'b1;
            wait_lvl(system_reset_n, 1'b1, 400, n);
            win(n, HOLD_T[s]);
        end
        // brownout and dip left bit 0 set; clear it before counting flags
        bus(1'b1, A_IRQS, 32'h0000_000F);
        // a low enable freezes the synchroniser, so the drop never shows
        ce <= 1'b0;
        second_supply_sense <= 1'b0;
        tick(10);
        chkb(second_supply_fail_n, 1'b1);
        second_supply_sense <= 1'b1;
        ce <= 1'b1;
        // fail flags follow their comparators, with irq masking
        bus(1'b1, A_MASK, 32'h0000_0002);
        second_supply_sense <= 1'b0;
        third_supply_sense <= 1'b0;
        wait_lvl(second_supply_fail_n, 1'b0, 5, n);
        wait_lvl(third_supply_fail_n, 1'b0, 5, n);
        wait_lvl(irq, 1'b1, 5, n);
        chkb(system_reset_n, 1'b1);
        second_supply_sense <= 1'b1;
        third_supply_sense <= 1'b1;
        wait_lvl(second_supply_fail_n, 1'b1, 5, n);
        wait_lvl(third_supply_fail_n, 1'b1, 5, n);
        rdchk(A_IRQS, 32'h0000_0006);
        bus(1'b1, A_IRQS, 32'h0000_0002);
        rdchk(A_IRQS, 32'h0000_0004);
        chkb(irq, 1'b0);
        bus(1'b1, A_IRQS, 32'h0000_0004);
        // watchdog periods; a bare start-stop must not restart it
        bus(1'b1, A_MASK, 32'h0000_0008);
        for (int s = 0; s < 3; s++) begin
            bus(1'b1, A_CTRL, 32'((s << 2) | 1));
            host(2'h0);
            wait_lvl(watchdog_expired_n, 1'b1, 10, n);
            wait_lvl(watchdog_expired_n, 1'b0, 400, n);
            win(n, WD_T[s]);
            tick(2);
            chkb(irq, 1'b1);
            if (s == 0) begin
                host(2'h2);
                tick(8);
                chkb(watchdog_expired_n, 1'b0);
            end
            host(2'h1);
            wait_lvl(watchdog_expired_n, 1'b1, 10, n);
            bus(1'b1, A_IRQS, 32'h0000_0008);
        end
        bus(1'b1, A_CTRL, 32'h0000_000D);
        wait_lvl(watchdog_expired_n, 1'b1, 5, n);
        tick(2 * WD_T[0] * TC);
        chkb(watchdog_expired_n, 1'b1);
        end_sim();
    end
endmodule : srw_supervisor_tb
